// ==== src/fmr_bank.sv ====
// Module configuration and status register bank.
`timescale 1ns/1ns
`include "fmr_cfg.svh"
module fmr_bank (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire fmr_pkg::fmr_sub_t SUB,
  input wire fmr_pkg::fmr_word_t WDATA,
  input wire logic [3:0] INPUT_LINES,
  input wire logic MOTOR_LINK_OK,
  input wire logic NET_CYCLE,
  input wire logic SAVED_PROFILE,
  input wire fmr_pkg::fmr_half_t SAVED_POLL,
  input wire fmr_pkg::fmr_half_t SAVED_ALIAS,
  output logic [31:0] RDATA,
  output logic RD_VALID,
  output logic WR_DENIED,
  output logic OUTPUT_LINE_ONE,
  output logic OUTPUT_LINE_TWO,
  output logic [3:0] NEGATIVE_LIMIT_SELECT,
  output logic [3:0] POSITIVE_LIMIT_SELECT,
  output logic CMD_STROBE,
  output logic [31:0] CMD_WORD,
  output logic MOTOR_UPDATE,
  output logic DRIVE_PROFILE_ON,
  output logic [15:0] ACTIVE_POLL,
  output logic [15:0] ACTIVE_ALIAS,
  output logic MAP_TAKEN
);
  import fmr_pkg::*;

  // ****************************************
  // Reset release and access filter.
  // ****************************************
  logic rst_a_q;
  logic rst_n;
  fmr_state_t st_q;
  fmr_word_t setup_q;
  fmr_word_t map_q [0:15];
  fmr_word_t map_act_q [0:15];
  fmr_half_t poll_q;
  fmr_half_t alias_q;
  fmr_half_t div_cnt_q;
  fmr_acc_if acc ();

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_a_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n <= rst_a_q;
    end
  end

  assign acc.wr_en = WR_EN;
  assign acc.sub = SUB;
  assign acc.wdata = WDATA;
  fmr_filter u_filter (.acc(acc));

  function automatic logic hit(input fmr_sub_t s, input fmr_sub_t want);
    hit = (s == want);
  endfunction : hit

  function automatic logic is_map(input fmr_sub_t s);
    is_map = (s >= `FMR_SUB_TX_LO) && (s <= `FMR_SUB_RX_HI);
  endfunction : is_map

  // ****************************************
  // Writable registers.
  // ****************************************
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= `FMR_ZERO32;
      poll_q <= `FMR_POLL_RESET;
      alias_q <= 16'h0000;
      NEGATIVE_LIMIT_SELECT <= 4'h0;
      POSITIVE_LIMIT_SELECT <= 4'h0;
      OUTPUT_LINE_ONE <= 1'b0;
      OUTPUT_LINE_TWO <= 1'b0;
    end else if (CLK_EN) begin
      if (st_q == FMR_LOAD) begin
        setup_q <= {28'h0000000, SAVED_PROFILE, 3'h0};
        poll_q <= SAVED_POLL;
        alias_q <= SAVED_ALIAS;
      end else if (acc.ok) begin
        if (hit(SUB, `FMR_SUB_SETUP))
          setup_q <= acc.fdata;
        if (hit(SUB, `FMR_SUB_OUT)) begin
          OUTPUT_LINE_ONE <= acc.fdata[0];
          OUTPUT_LINE_TWO <= acc.fdata[1];
        end
        if (hit(SUB, `FMR_SUB_POLL))
          poll_q <= acc.fdata[15:0];
        if (hit(SUB, `FMR_SUB_ALIAS))
          alias_q <= acc.fdata[15:0];
        if (hit(SUB, `FMR_SUB_MASK)) begin
          NEGATIVE_LIMIT_SELECT <= acc.fdata[`FMR_NEG_LSB +: 4];
          POSITIVE_LIMIT_SELECT <= acc.fdata[`FMR_POS_LSB +: 4];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++)
        map_q[i] <= `FMR_ZERO32;
    end else if (CLK_EN && acc.ok && is_map(SUB)) begin
      map_q[SUB[3:0]] <= acc.fdata;
    end
  end

  // ****************************************
  // Boot sequence: values active only after reset.
  // ****************************************
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= FMR_BOOT;
      DRIVE_PROFILE_ON <= 1'b0;
      ACTIVE_POLL <= `FMR_POLL_RESET;
      ACTIVE_ALIAS <= 16'h0000;
      MAP_TAKEN <= 1'b0;
      for (int i = 0; i < 16; i++)
        map_act_q[i] <= `FMR_ZERO32;
    end else if (CLK_EN) begin
      case (st_q)
        FMR_BOOT: st_q <= FMR_LOAD;
        FMR_LOAD: begin
          DRIVE_PROFILE_ON <= SAVED_PROFILE;
          ACTIVE_POLL <= SAVED_POLL;
          ACTIVE_ALIAS <= SAVED_ALIAS;
          st_q <= FMR_RUN;
        end
        FMR_RUN: begin
          if (!MAP_TAKEN) begin
            for (int i = 0; i < 16; i++)
              map_act_q[i] <= map_q[i];
            MAP_TAKEN <= 1'b1;
          end
        end
        default: st_q <= FMR_BOOT;
      endcase
    end
  end

  // ****************************************
  // Command pulse and motor poll divider.
  // ****************************************
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CMD_STROBE <= 1'b0;
      CMD_WORD <= `FMR_ZERO32;
      WR_DENIED <= 1'b0;
    end else if (CLK_EN) begin
      CMD_STROBE <= acc.ok && hit(SUB, `FMR_SUB_CMD);
      if (acc.ok && hit(SUB, `FMR_SUB_CMD))
        CMD_WORD <= WDATA;
      WR_DENIED <= WR_EN && !acc.ok;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 16'h0000;
      MOTOR_UPDATE <= 1'b0;
    end else if (CLK_EN) begin
      MOTOR_UPDATE <= 1'b0;
      if (NET_CYCLE && st_q == FMR_RUN) begin
        if (div_cnt_q + 16'h0001 >= ACTIVE_POLL) begin
          div_cnt_q <= 16'h0000;
          MOTOR_UPDATE <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // Read path.
  // ****************************************
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= `FMR_ZERO32;
      RD_VALID <= 1'b0;
    end else if (CLK_EN) begin
      RD_VALID <= RD_EN;
      if (RD_EN) begin
        RDATA <= `FMR_ZERO32;
        case (SUB)
          `FMR_SUB_SETUP: RDATA <= setup_q;
          `FMR_SUB_OUT: RDATA <= {30'h00000000, OUTPUT_LINE_TWO,
            OUTPUT_LINE_ONE};
          `FMR_SUB_POLL: RDATA <= {16'h0000, poll_q};
          `FMR_SUB_ALIAS: RDATA <= {16'h0000, alias_q};
          `FMR_SUB_MASK: RDATA <= {20'h00000, POSITIVE_LIMIT_SELECT,
            4'h0, NEGATIVE_LIMIT_SELECT};
          `FMR_SUB_CMD: RDATA <= CMD_WORD;
          `FMR_SUB_IN: RDATA <= {28'h0000000, INPUT_LINES};
          `FMR_SUB_STAT: RDATA <= {24'h000000, !MOTOR_LINK_OK,
            7'h00};
          default: begin
            if (is_map(SUB))
              RDATA <= map_q[SUB[3:0]];
          end
        endcase
      end
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  property p_ro_denied;
    @(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && WR_EN &&
      (SUB < `FMR_SUB_RW_LO || SUB > `FMR_SUB_RW_HI)) |=> WR_DENIED;
  endproperty
  a_ro_denied: assert property (p_ro_denied)
    else $error("Write to read-only subindex not denied.");

  property p_out_follow;
    @(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && acc.ok && SUB == `FMR_SUB_OUT && st_q == FMR_RUN)
      |=> (OUTPUT_LINE_ONE == $past(WDATA[0]));
  endproperty
  a_out_follow: assert property (p_out_follow)
    else $error("Output line one does not follow write.");

  property p_cmd_pulse;
    @(posedge REF_CLK) disable iff (!rst_n)
      (CMD_STROBE && $past(CLK_EN)) |->
      $past(acc.ok && SUB == `FMR_SUB_CMD);
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("Command strobe without a command write.");

  property p_stat;
    @(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && RD_EN && SUB == `FMR_SUB_STAT)
      |=> RDATA[`FMR_STAT_NOLINK] == !$past(MOTOR_LINK_OK)
      && RDATA[6:0] == 7'h00;
  endproperty
  a_stat: assert property (p_stat)
    else $error("Status link flag wrong.");

  property p_inputs;
    @(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && RD_EN && SUB == `FMR_SUB_IN)
      |=> RDATA == {28'h0000000, $past(INPUT_LINES)};
  endproperty
  a_inputs: assert property (p_inputs)
    else $error("Input levels read wrong.");

  property p_alias_hold;
    @(posedge REF_CLK) disable iff (!rst_n)
      (st_q == FMR_RUN) |=> $stable(ACTIVE_ALIAS) && $stable(ACTIVE_POLL);
  endproperty
  a_alias_hold: assert property (p_alias_hold)
    else $error("Active alias or divider changed after boot.");

  property p_profile_hold;
    @(posedge REF_CLK) disable iff (!rst_n)
      (st_q == FMR_RUN) |=> $stable(DRIVE_PROFILE_ON);
  endproperty
  a_profile_hold: assert property (p_profile_hold)
    else $error("Profile changed without power cycle.");

  property p_mask_res;
    @(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && RD_EN && SUB == `FMR_SUB_MASK) |=> RDATA[7:4] == 4'h0
      && RDATA[31:12] == 20'h00000;
  endproperty
  a_mask_res: assert property (p_mask_res)
    else $error("Reserved mask bits read nonzero.");

  property p_div;
    @(posedge REF_CLK) disable iff (!rst_n)
      (MOTOR_UPDATE && $past(CLK_EN)) |-> $past(NET_CYCLE);
  endproperty
  a_div: assert property (p_div)
    else $error("Motor update without network cycle.");

  c_cmd: cover property (@(posedge REF_CLK) CMD_STROBE);
  c_upd: cover property (@(posedge REF_CLK) MOTOR_UPDATE);
  c_den: cover property (@(posedge REF_CLK) WR_DENIED);
endmodule : fmr_bank

// ==== include/fmr_cfg.svh ====
// Constants for the module register bank: subindices, fields and resets.
`ifndef FMR_CFG_SVH
`define FMR_CFG_SVH
`define FMR_SUB_SETUP 6'h06
`define FMR_SUB_OUT 6'h07
`define FMR_SUB_POLL 6'h08
`define FMR_SUB_ALIAS 6'h09
`define FMR_SUB_MASK 6'h0b
`define FMR_SUB_CMD 6'h0f
`define FMR_SUB_TX_LO 6'h10
`define FMR_SUB_TX_HI 6'h17
`define FMR_SUB_RX_LO 6'h18
`define FMR_SUB_RX_HI 6'h1f
`define FMR_SUB_RW_LO 6'h03
`define FMR_SUB_RW_HI 6'h1f
`define FMR_SUB_IN 6'h2f
`define FMR_SUB_STAT 6'h30
`define FMR_SETUP_MASK 32'h0000007f
`define FMR_SETUP_PROFILE 3
`define FMR_OUT_MASK 32'h00000003
`define FMR_HALF_MASK 32'h0000ffff
`define FMR_LIMIT_MASK 32'h00000f0f
`define FMR_NEG_LSB 0
`define FMR_POS_LSB 8
`define FMR_IN_MASK 32'h0000000f
`define FMR_STAT_NOLINK 7
`define FMR_ZERO32 32'h00000000
`define FMR_POLL_RESET 16'h0001
`define FMR_MAP_ENTRIES 8
`endif

// ==== include/fmr_pkg.sv ====
// Types shared by the module register bank.
package fmr_pkg;
  typedef logic [5:0] fmr_sub_t;
  typedef logic [31:0] fmr_word_t;
  typedef logic [15:0] fmr_half_t;
  typedef enum logic [1:0] {FMR_BOOT, FMR_LOAD, FMR_RUN} fmr_state_t;
endpackage : fmr_pkg

// ==== include/fmr_acc_if.sv ====
// Access channel between the bank and its write filter.
`timescale 1ns/1ns
interface fmr_acc_if;
  import fmr_pkg::*;
  logic wr_en;
  fmr_sub_t sub;
  fmr_word_t wdata;
  logic ok;
  fmr_word_t fdata;
  modport bank (output wr_en, output sub, output wdata, input ok,
    input fdata);
  modport filt (input wr_en, input sub, input wdata, output ok,
    output fdata);
endinterface : fmr_acc_if

// ==== src/fmr_filter.sv ====
// Write filter: decides writability and masks reserved bits.
`timescale 1ns/1ns
`include "fmr_cfg.svh"
module fmr_filter (
  fmr_acc_if.filt acc
);
  import fmr_pkg::*;

  function automatic fmr_word_t keep_mask(input fmr_sub_t s);
    case (s)
      `FMR_SUB_SETUP: keep_mask = `FMR_SETUP_MASK;
      `FMR_SUB_OUT: keep_mask = `FMR_OUT_MASK;
      `FMR_SUB_POLL: keep_mask = `FMR_HALF_MASK;
      `FMR_SUB_ALIAS: keep_mask = `FMR_HALF_MASK;
      `FMR_SUB_MASK: keep_mask = `FMR_LIMIT_MASK;
      default: keep_mask = ~`FMR_ZERO32;
    endcase
  endfunction : keep_mask

  // Only subindices 3 to 31 accept writes.
  assign acc.ok = acc.wr_en && (acc.sub >= `FMR_SUB_RW_LO) &&
    (acc.sub <= `FMR_SUB_RW_HI);
  assign acc.fdata = acc.wdata & keep_mask(acc.sub);
endmodule : fmr_filter

// ==== verification/fmr_net_model.sv ====
// Network side model: makes net cycle pulses and counts motor updates.
`timescale 1ns/1ns
module fmr_net_model #(
  parameter int PERIOD = 5
) (
  input wire logic clk,
  input wire logic run,
  input wire logic motor_update,
  output logic net_cycle,
  output int net_count,
  output int upd_count
);
  int div_q;
  initial begin
    net_cycle = 1'b0;
    net_count = 0;
    upd_count = 0;
    div_q = 0;
  end
  // ****************************************
  // Pulse source and update counter.
  // ****************************************
  always @(posedge clk) begin
    if (motor_update === 1'b1) begin
      upd_count <= upd_count + 1;
    end
  end
  always @(negedge clk) begin
    net_cycle <= run && (div_q == PERIOD - 1);
    div_q <= (!run || div_q == PERIOD - 1) ? 0 : div_q + 1;
    if (run && div_q == PERIOD - 1) begin
      net_count <= net_count + 1;
    end
  end
endmodule : fmr_net_model

// ==== verification/testbench.sv ====
// Self-checking testbench for the module register bank.
`timescale 1ns/1ns
module testbench;
  import fmr_pkg::*;
  logic clk, rst_n, wr_en, rd_en, link_ok, net_run, saved_prof, net_cycle;
  logic clk_en;
  fmr_sub_t sub;
  fmr_word_t wdata, d;
  fmr_half_t saved_poll, saved_alias;
  logic [3:0] in_lines, neg_sel, pos_sel;
  logic [31:0] rdata, cmd_word, r;
  logic rd_valid, wr_denied, o1, o2, cmd_stb, upd, prof_on, map_taken;
  logic [15:0] act_poll, act_alias;
  int bad_count, check_count, cyc, net_n, upd_n, i, n0, u0;
  logic [31:0] exp_q[$];
  string name_q[$];
  fmr_sub_t tsub[5] = '{6'h06, 6'h07, 6'h08, 6'h09, 6'h0b};
  logic [31:0] tmsk[5] = '{32'h7f, 32'h3, 32'hffff, 32'hffff, 32'hf0f};
  fmr_sub_t dsub[8] = '{6'h00, 6'h02, 6'h20, 6'h2f, 6'h30, 6'h3f, 6'h03,
    6'h1f};
  fmr_bank uut (.REF_CLK(clk), .RESETN(rst_n), .CLK_EN(clk_en),
    .WR_EN(wr_en), .RD_EN(rd_en), .SUB(sub), .WDATA(wdata),
    .INPUT_LINES(in_lines), .MOTOR_LINK_OK(link_ok), .NET_CYCLE(net_cycle),
    .SAVED_PROFILE(saved_prof), .SAVED_POLL(saved_poll),
    .SAVED_ALIAS(saved_alias), .RDATA(rdata), .RD_VALID(rd_valid),
    .WR_DENIED(wr_denied), .OUTPUT_LINE_ONE(o1), .OUTPUT_LINE_TWO(o2),
    .NEGATIVE_LIMIT_SELECT(neg_sel), .POSITIVE_LIMIT_SELECT(pos_sel),
    .CMD_STROBE(cmd_stb), .CMD_WORD(cmd_word), .MOTOR_UPDATE(upd),
    .DRIVE_PROFILE_ON(prof_on), .ACTIVE_POLL(act_poll),
    .ACTIVE_ALIAS(act_alias), .MAP_TAKEN(map_taken));
  fmr_net_model net (.clk(clk), .run(net_run), .motor_update(upd),
    .net_cycle(net_cycle), .net_count(net_n), .upd_count(upd_n));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // ****************************************
  // Shared tasks.
  // ****************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task do_reset;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : do_reset
  task wr(input fmr_sub_t s, input fmr_word_t v, input logic deny);
    @(negedge clk);
    wr_en = 1'b1;
    sub = s;
    wdata = v;
    @(negedge clk);
    wr_en = 1'b0;
    chk("write refused", {31'h0, deny}, {31'h0, wr_denied});
    chk("command strobe", {31'h0, s == 6'h0f}, {31'h0, cmd_stb});
  endtask : wr
  task rd(input fmr_sub_t s, input string nm, input logic [31:0] e);
    @(negedge clk);
    rd_en = 1'b1;
    sub = s;
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(negedge clk);
    rd_en = 1'b0;
  endtask : rd
  task mcheck(input int p);
    u0 = upd_n;
    n0 = net_n;
    net_run = 1'b1;
    for (i = 0; i < 500 && net_n < n0 + 6 * p; i++) @(negedge clk);
    net_run = 1'b0;
    repeat (3) @(negedge clk);
    chk("motor updates", 32'h6, upd_n - u0);
  endtask : mcheck
  // ****************************************
  // Result watcher and timeout.
  // ****************************************
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("FAIL unexpected read expected none seen %h", rdata);
      end else begin
        chk(name_q.pop_front(), exp_q.pop_front(), rdata);
      end
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    r = $urandom(84541);
    {rst_n, wr_en, rd_en, net_run, sub, wdata, in_lines} = '0;
    {link_ok, saved_prof, saved_poll} = {2'b11, 16'h0003};
    clk_en = 1'b1;
    saved_alias = 16'($urandom);
    do_reset;
    chk("profile", 32'h1, {31'h0, prof_on});
    chk("poll", 32'h3, {16'h0, act_poll});
    chk("alias", {16'h0, saved_alias}, {16'h0, act_alias});
    chk("map taken", 32'h1, {31'h0, map_taken});
    mcheck(3);
    for (i = 0; i < 5; i++) begin
      d = $urandom;
      wr(tsub[i], d, 1'b0);
      rd(tsub[i], "readback", d & tmsk[i]);
    end
    chk("negative limits", {28'h0, d[3:0]}, {28'h0, neg_sel});
    chk("positive limits", {28'h0, d[11:8]}, {28'h0, pos_sel});
    chk("poll held", 32'h3, {16'h0, act_poll});
    chk("profile held", 32'h1, {31'h0, prof_on});
    for (i = 0; i < 4; i++) begin
      wr(6'h07, ($urandom & 32'hfffffffc) | i, 1'b0);
      chk("outputs", i, {30'h0, o2, o1});
    end
    clk_en = 1'b0;
    wr(6'h07, 32'h0, 1'b0);
    chk("outputs frozen", 32'h3, {30'h0, o2, o1});
    clk_en = 1'b1;
    for (i = 0; i < 8; i++) wr(dsub[i], $urandom, i < 6);
    d = $urandom;
    wr(6'h0f, d, 1'b0);
    chk("command word", d, cmd_word);
    d = $urandom & 32'hff;
    wr(6'h10, d, 1'b0);
    rd(6'h10, "send map", d);
    wr(6'h18, d ^ 32'h5a, 1'b0);
    rd(6'h18, "receive map", d ^ 32'h5a);
    in_lines = 4'($urandom);
    rd(6'h2f, "inputs", {28'h0, in_lines});
    link_ok = 1'b0;
    rd(6'h30, "status", 32'h80);
    link_ok = 1'b1;
    rd(6'h30, "status", 32'h0);
    repeat (2) @(negedge clk);
    saved_prof = 1'b0;
    saved_poll = 16'h0002 + 16'($urandom % 4);
    do_reset;
    chk("profile", 32'h0, {31'h0, prof_on});
    chk("poll", {16'h0, saved_poll}, {16'h0, act_poll});
    rd(6'h07, "outputs reset", 32'h0);
    mcheck(saved_poll);
    repeat (3) @(negedge clk);
    chk("queue empty", 32'h0, exp_q.size());
    report_and_stop;
  end
endmodule : testbench
